/* File: design/tld_pkg.sv */
/*
  Constants, register map and state type of the text and line drawing
  engine. Assumes a 32-bit classic Wishbone slave port with byte addresses
  and a 32-bit frame buffer master port with byte addresses.
*/
// Operation
// - host data words give one pixel per bit
// - ones foreground, zeros background or left alone
// - any of 256 raster operations, written back
// - packed lines contiguous, trailing bits never drawn
// - byte zero first, msb first, top line first
// - pattern row fetched at each scan line start
// - five low source coordinate bits align packed data
// - destination coordinate write launches the operation
// - full data port stalls the bus cycle silently
// - destination write takes width from address bits, height for vertical lines
// - coordinates and width are double buffered
// - lines use background colour as source
// - horizontal segment length goes into width
// - vertical segment length goes into height
// - other dimension gives line thickness
package tld_pkg;

  // register byte offsets
  localparam logic [11:0] OFS_CTRL    = 12'h000;
  localparam logic [11:0] OFS_FG      = 12'h004;
  localparam logic [11:0] OFS_BG      = 12'h008;
  localparam logic [11:0] OFS_WIDTH   = 12'h00c;
  localparam logic [11:0] OFS_HEIGHT  = 12'h010;
  localparam logic [11:0] OFS_SOURCE_COORD_REG  = 12'h014;
  localparam logic [11:0] OFS_BASE    = 12'h018;
  localparam logic [11:0] OFS_PITCH   = 12'h01c;
  localparam logic [11:0] OFS_PATTERN = 12'h020;
  localparam logic [11:0] OFS_BPP     = 12'h024;
  localparam logic [11:0] OFS_STATUS  = 12'h028;
  localparam logic [11:0] OFS_DATA    = 12'h02c;
  // destination coordinate window: bit 11 set, count in bits 10..2
  localparam int          DST_WIN_BIT = 11;
  localparam int          CNT_LSB     = 2;
  localparam int          CNT_MSB     = 10;

  // control register fields
  localparam int CTL_ROP_LSB  = 0;
  localparam int CTL_ROP_MSB  = 7;
  localparam int CTL_EXPAND   = 8;
  localparam int CTL_TRANSP   = 9;
  localparam int CTL_PACKED   = 10;
  localparam int CTL_SRC_HOST = 11;
  localparam int CTL_PAT_EN   = 12;
  localparam int CTL_MODE_LSB = 13;
  localparam int CTL_MODE_MSB = 14;
  localparam int CTL_BITS     = 15;

  localparam logic [1:0] MODE_HOST  = 2'h0;
  localparam logic [1:0] MODE_HLINE = 2'h1;
  localparam logic [1:0] MODE_VLINE = 2'h2;

  // status register fields
  localparam int STS_BUSY = 0;
  localparam int STS_PEND = 1;
  localparam int STS_HOLD = 2;

  // reset values
  localparam logic [CTL_BITS-1:0] CTRL_RST = 15'h00cc;
  localparam logic [2:0]          BPP_RST  = 3'h1;
  localparam logic [31:0]         ZERO32   = 32'h0000_0000;
  localparam logic [31:0]         ONES32   = 32'hffff_ffff;

  // host data and pattern geometry
  localparam logic [4:0] LAST_BIT     = 5'h1f;
  localparam logic [4:0] PACK_ALIGN_W = 5'h1f;
  localparam int         PAT_ROWS     = 8;
  localparam logic [2:0] PAT_ROW_MASK = 3'h7;
  localparam logic [3:0] PAT_ROW_SHFT = 4'h2;

  typedef enum logic [2:0] {
    TLD_IDLE = 3'b000,
    TLD_LINE = 3'b001,
    TLD_PAT  = 3'b011,
    TLD_SRC  = 3'b010,
    TLD_RD   = 3'b110,
    TLD_WR   = 3'b111,
    TLD_NEXT = 3'b101
  } tld_state_t;

endpackage : tld_pkg

/* File: design/tld_rop.sv */
/*
  Bitwise raster operation unit: each result bit picks one bit of the
  eight-bit operation code indexed by pattern, source and destination.
  Assumes colour words already expanded to full pixel width.
*/
module tld_rop (
  input  wire logic [7:0]  rop_i,
  input  wire logic [31:0] src_i,
  input  wire logic [31:0] pat_i,
  input  wire logic [31:0] dst_i,
  output logic      [31:0] res_o
);

  always_comb begin
    res_o = 32'h0000_0000;
    for (int i = 0; i < 32; i++) begin
      res_o[i] = rop_i[{pat_i[i], src_i[i], dst_i[i]}];
    end
  end

endmodule // tld_rop

/* File: design/tld_engine.sv */
/*
  Text and line drawing engine: Wishbone register slave with data port,
  double-buffered destination coordinates and a frame buffer master that
  reads, combines and writes one pixel at a time. Assumes a frame buffer
  port that answers each request with a one-cycle ack.
*/
// Local design decisions: the register offsets and the Wishbone interface to the registers.
module tld_engine (
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             fb_cyc_o,
  output logic             fb_stb_o,
  output logic             fb_we_o,
  output logic      [31:0] fb_adr_o,
  output logic      [3:0]  fb_sel_o,
  output logic      [31:0] fb_dat_o,
  input  wire logic [31:0] fb_dat_i,
  input  wire logic        fb_ack_i,
  output logic             busy_o
);

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return r;
  endfunction

  // byte zero first, msb of each byte first
  function automatic logic bit_at(input logic [31:0] w,
                                  input logic [4:0]  k);
    return w[{k[4:3], ~k[2:0]}];
  endfunction

  // registers
  logic [tld_pkg::CTL_BITS-1:0] ctrl_q, ctrl_d;
  logic [31:0] fg_q, fg_d, bg_q, bg_d, srcxy_q, srcxy_d;
  logic [31:0] base_q, base_d, pat_q, pat_d;
  logic [15:0] width_q, width_d, height_q, height_d, pitch_q, pitch_d;
  logic [2:0]  bpp_q, bpp_d;
  logic        pend_q, pend_d;
  logic [15:0] pend_x_q, pend_x_d, pend_y_q, pend_y_d;
  logic [15:0] pend_w_q, pend_w_d, pend_h_q, pend_h_d;
  logic [31:0] hold_q, hold_d;
  logic        hold_v_q, hold_v_d;
  logic        ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  // engine
  tld_pkg::tld_state_t st_q, st_d;
  logic [15:0] act_w_q, act_w_d, rows_q, rows_d, row_q, row_d;
  logic [15:0] bytep_q, bytep_d, xpix_q, xpix_d, x0_q, x0_d;
  logic [31:0] line_q, line_d, adr_q, adr_d, wdat_q, wdat_d;
  logic [31:0] src_q, src_d;
  logic [7:0]  prow_q, prow_d;
  logic [4:0]  bitp_q, bitp_d;
  logic        consume;

  logic        req, take, ok, is_dst;
  logic [8:0]  cnt;
  logic [1:0]  mode;
  logic        packed_f, expand_f, transp_f, host_f, pat_f;
  logic [31:0] pat_word, rop_res;
  logic        sbit, pbit;

  assign req      = wb_cyc_i && wb_stb_i && !ack_q;
  assign is_dst   = wb_adr_i[tld_pkg::DST_WIN_BIT];
  assign cnt      = wb_adr_i[tld_pkg::CNT_MSB:tld_pkg::CNT_LSB];
  assign mode     = ctrl_q[tld_pkg::CTL_MODE_MSB:tld_pkg::CTL_MODE_LSB];
  assign packed_f = ctrl_q[tld_pkg::CTL_PACKED];
  assign expand_f = ctrl_q[tld_pkg::CTL_EXPAND];
  assign transp_f = ctrl_q[tld_pkg::CTL_TRANSP];
  assign pat_f    = ctrl_q[tld_pkg::CTL_PAT_EN];
  assign host_f   = ctrl_q[tld_pkg::CTL_SRC_HOST] &&
                    (mode == tld_pkg::MODE_HOST);
  assign sbit     = bit_at(hold_q, bitp_q);
  assign pbit     = prow_q[~xpix_q[2:0]];
  assign pat_word = !pat_f ? tld_pkg::ONES32 : (pbit ? fg_q : bg_q);

  // a full data port or a full coordinate buffer withholds ack
  always_comb begin
    ok = 1'b1;
    if (wb_we_i && is_dst) begin
      ok = !pend_q;
    end else if (wb_we_i && wb_adr_i == tld_pkg::OFS_DATA) begin
      ok = !hold_v_q;
    end
  end
  assign take = req && ok;

  tld_rop u_rop (
    .rop_i (ctrl_q[tld_pkg::CTL_ROP_MSB:tld_pkg::CTL_ROP_LSB]),
    .src_i (src_q),
    .pat_i (pat_word),
    .dst_i (fb_dat_i),
    .res_o (rop_res)
  );

  // register file and bus slave
  always_comb begin
    ctrl_d = ctrl_q; fg_d = fg_q; bg_d = bg_q; srcxy_d = srcxy_q;
    base_d = base_q; pat_d = pat_q; width_d = width_q;
    height_d = height_q; pitch_d = pitch_q; bpp_d = bpp_q;
    pend_d = pend_q; pend_x_d = pend_x_q; pend_y_d = pend_y_q;
    pend_w_d = pend_w_q; pend_h_d = pend_h_q;
    hold_d = hold_q; hold_v_d = hold_v_q;
    ack_d = take;
    rdat_d = rdat_q;
    if (consume) hold_v_d = 1'b0;
    if (st_q == tld_pkg::TLD_IDLE && pend_q) pend_d = 1'b0;
    if (take && wb_we_i) begin
      if (is_dst) begin
        pend_d   = 1'b1;
        pend_x_d = wb_dat_i[15:0];
        pend_y_d = wb_dat_i[31:16];
        if (mode == tld_pkg::MODE_VLINE) begin
          pend_w_d = width_q;
          pend_h_d = {7'h00, cnt};
        end else begin
          pend_w_d = {7'h00, cnt};
          pend_h_d = height_q;
        end
      end else if (wb_adr_i == tld_pkg::OFS_CTRL) begin
        ctrl_d = tld_pkg::CTL_BITS'(merge(32'(ctrl_q), wb_dat_i,
                                          wb_sel_i));
      end else if (wb_adr_i == tld_pkg::OFS_FG) begin
        fg_d = merge(fg_q, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == tld_pkg::OFS_BG) begin
        bg_d = merge(bg_q, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == tld_pkg::OFS_WIDTH) begin
        width_d = 16'(merge(32'(width_q), wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == tld_pkg::OFS_HEIGHT) begin
        height_d = 16'(merge(32'(height_q), wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == tld_pkg::OFS_SOURCE_COORD_REG) begin
        srcxy_d = merge(srcxy_q, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == tld_pkg::OFS_BASE) begin
        base_d = merge(base_q, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == tld_pkg::OFS_PITCH) begin
        pitch_d = 16'(merge(32'(pitch_q), wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == tld_pkg::OFS_PATTERN) begin
        pat_d = merge(pat_q, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == tld_pkg::OFS_BPP) begin
        if (wb_sel_i[0] && wb_dat_i[2:0] != 3'h0) bpp_d = wb_dat_i[2:0];
      end else if (wb_adr_i == tld_pkg::OFS_DATA) begin
        hold_d   = wb_dat_i;
        hold_v_d = 1'b1;
      end
    end
    if (take && !wb_we_i) begin
      rdat_d = tld_pkg::ZERO32;
      if (wb_adr_i == tld_pkg::OFS_CTRL) begin
        rdat_d = 32'(ctrl_q);
      end else if (wb_adr_i == tld_pkg::OFS_FG) begin
        rdat_d = fg_q;
      end else if (wb_adr_i == tld_pkg::OFS_BG) begin
        rdat_d = bg_q;
      end else if (wb_adr_i == tld_pkg::OFS_WIDTH) begin
        rdat_d = 32'(width_q);
      end else if (wb_adr_i == tld_pkg::OFS_HEIGHT) begin
        rdat_d = 32'(height_q);
      end else if (wb_adr_i == tld_pkg::OFS_SOURCE_COORD_REG) begin
        rdat_d = srcxy_q;
      end else if (wb_adr_i == tld_pkg::OFS_BASE) begin
        rdat_d = base_q;
      end else if (wb_adr_i == tld_pkg::OFS_PITCH) begin
        rdat_d = 32'(pitch_q);
      end else if (wb_adr_i == tld_pkg::OFS_PATTERN) begin
        rdat_d = pat_q;
      end else if (wb_adr_i == tld_pkg::OFS_BPP) begin
        rdat_d = 32'(bpp_q);
      end else if (wb_adr_i == tld_pkg::OFS_STATUS) begin
        rdat_d[tld_pkg::STS_BUSY] = busy_o;
        rdat_d[tld_pkg::STS_PEND] = pend_q;
        rdat_d[tld_pkg::STS_HOLD] = hold_v_q;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      ctrl_q <= tld_pkg::CTRL_RST; fg_q <= tld_pkg::ZERO32;
      bg_q <= tld_pkg::ZERO32; srcxy_q <= tld_pkg::ZERO32;
      base_q <= tld_pkg::ZERO32; pat_q <= tld_pkg::ZERO32;
      width_q <= 16'h0000; height_q <= 16'h0000; pitch_q <= 16'h0000;
      bpp_q <= tld_pkg::BPP_RST; pend_q <= 1'b0;
      pend_x_q <= 16'h0000; pend_y_q <= 16'h0000;
      pend_w_q <= 16'h0000; pend_h_q <= 16'h0000;
      hold_q <= tld_pkg::ZERO32; hold_v_q <= 1'b0;
      ack_q <= 1'b0; rdat_q <= tld_pkg::ZERO32;
    end else begin
      ctrl_q <= ctrl_d; fg_q <= fg_d; bg_q <= bg_d; srcxy_q <= srcxy_d;
      base_q <= base_d; pat_q <= pat_d; width_q <= width_d;
      height_q <= height_d; pitch_q <= pitch_d; bpp_q <= bpp_d;
      pend_q <= pend_d; pend_x_q <= pend_x_d; pend_y_q <= pend_y_d;
      pend_w_q <= pend_w_d; pend_h_q <= pend_h_d;
      hold_q <= hold_d; hold_v_q <= hold_v_d;
      ack_q <= ack_d; rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // drawing engine
  always_comb begin
    st_d = st_q; act_w_d = act_w_q; rows_d = rows_q; row_d = row_q;
    bytep_d = bytep_q; xpix_d = xpix_q; x0_d = x0_q; line_d = line_q;
    adr_d = adr_q; wdat_d = wdat_q; src_d = src_q; prow_d = prow_q;
    bitp_d = bitp_q; consume = 1'b0;
    case (st_q)
      tld_pkg::TLD_IDLE: begin
        if (pend_q) begin
          act_w_d = pend_w_q;
          // packed host text height counts lines, others count lines minus one
          rows_d  = packed_f && host_f ? pend_h_q : pend_h_q + 16'h0001;
          row_d   = 16'h0000;
          bytep_d = 16'h0000;
          x0_d    = pend_x_q;
          xpix_d  = pend_x_q;
          line_d  = base_q + pend_y_q * pitch_q +
                    32'(pend_x_q) * 32'(bpp_q);
          bitp_d  = packed_f ? srcxy_q[4:0]
                             : {srcxy_q[2:0], 2'b00} << 1;
          st_d    = tld_pkg::TLD_LINE;
        end
      end
      tld_pkg::TLD_LINE: begin
        if (rows_q == 16'h0000) begin
          st_d = tld_pkg::TLD_IDLE;
        end else if (pat_f) begin
          adr_d = pat_q + (32'(row_q[2:0] & tld_pkg::PAT_ROW_MASK)
                           << tld_pkg::PAT_ROW_SHFT);
          st_d  = tld_pkg::TLD_PAT;
        end else begin
          st_d = tld_pkg::TLD_SRC;
        end
      end
      tld_pkg::TLD_PAT: begin
        if (fb_ack_i) begin
          prow_d = fb_dat_i[7:0];
          st_d   = tld_pkg::TLD_SRC;
        end
      end
      tld_pkg::TLD_SRC: begin
        adr_d = line_q + 32'(bytep_q);
        if (!host_f) begin
          src_d = bg_q;
          st_d  = tld_pkg::TLD_RD;
        end else if (hold_v_q) begin
          if (expand_f) begin
            src_d  = sbit ? fg_q : bg_q;
            bitp_d = bitp_q + 5'h01;
            consume = (bitp_q == tld_pkg::LAST_BIT);
            st_d = (transp_f && !sbit) ? tld_pkg::TLD_NEXT
                                       : tld_pkg::TLD_RD;
          end else begin
            src_d   = hold_q;
            consume = 1'b1;
            st_d    = tld_pkg::TLD_RD;
          end
        end
      end
      tld_pkg::TLD_RD: begin
        if (fb_ack_i) begin
          wdat_d = rop_res;
          st_d   = tld_pkg::TLD_WR;
        end
      end
      tld_pkg::TLD_WR: begin
        if (fb_ack_i) st_d = tld_pkg::TLD_NEXT;
      end
      tld_pkg::TLD_NEXT: begin
        if (bytep_q + 16'(bpp_q) > act_w_q) begin
          // a partly used word holds only padding for this line
          if (host_f && expand_f && bitp_q != 5'h00 &&
              (!packed_f || row_q + 16'h0001 == rows_q)) begin
            consume = 1'b1;
            bitp_d  = 5'h00;
          end
          row_d   = row_q + 16'h0001;
          line_d  = line_q + 32'(pitch_q);
          bytep_d = 16'h0000;
          xpix_d  = x0_q;
          st_d    = (row_q + 16'h0001 == rows_q) ? tld_pkg::TLD_IDLE
                                                 : tld_pkg::TLD_LINE;
        end else begin
          bytep_d = bytep_q + 16'(bpp_q);
          xpix_d  = xpix_q + 16'h0001;
          st_d    = tld_pkg::TLD_SRC;
        end
      end
      default: st_d = tld_pkg::TLD_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      st_q <= tld_pkg::TLD_IDLE; act_w_q <= 16'h0000;
      rows_q <= 16'h0000; row_q <= 16'h0000; bytep_q <= 16'h0000;
      xpix_q <= 16'h0000; x0_q <= 16'h0000; line_q <= tld_pkg::ZERO32;
      adr_q <= tld_pkg::ZERO32; wdat_q <= tld_pkg::ZERO32;
      src_q <= tld_pkg::ZERO32; prow_q <= 8'h00; bitp_q <= 5'h00;
    end else begin
      st_q <= st_d; act_w_q <= act_w_d; rows_q <= rows_d;
      row_q <= row_d; bytep_q <= bytep_d; xpix_q <= xpix_d;
      x0_q <= x0_d; line_q <= line_d; adr_q <= adr_d;
      wdat_q <= wdat_d; src_q <= src_d; prow_q <= prow_d;
      bitp_q <= bitp_d;
    end
  end

  assign fb_cyc_o = st_q == tld_pkg::TLD_PAT || st_q == tld_pkg::TLD_RD ||
                    st_q == tld_pkg::TLD_WR;
  assign fb_stb_o = fb_cyc_o;
  assign fb_we_o  = st_q == tld_pkg::TLD_WR;
  assign fb_adr_o = adr_q;
  assign fb_dat_o = wdat_q;
  assign fb_sel_o = st_q == tld_pkg::TLD_PAT ? 4'hf
                    : 4'((5'h01 << bpp_q) - 5'h01);
  assign busy_o   = st_q != tld_pkg::TLD_IDLE || pend_q;

endmodule // tld_engine

/* File: sim/tld_assertions.sv */
/*
  Port checker for the drawing engine: bus handshakes, frame buffer
  access order and busy span. Assumes it is bound to tld_engine.
*/
module tld_assertions (
  input wire logic        ref_clk_i,
  input wire logic        resetn_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic        wb_ack_o,
  input wire logic        fb_stb_o,
  input wire logic        fb_cyc_o,
  input wire logic        fb_we_o,
  input wire logic [31:0] fb_adr_o,
  input wire logic [31:0] fb_dat_o,
  input wire logic        fb_ack_i,
  input wire logic        busy_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
  a_ack_has_req: assert property (
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("bus ack without request");
  a_launch_sets_busy: assert property (
    (wb_ack_o && wb_we_i && wb_adr_i[11]) |-> ##[0:2] busy_o)
    else $error("destination write did not start the engine");
  a_fb_in_busy: assert property (fb_cyc_o |-> busy_o)
    else $error("frame buffer access while idle");
  a_fb_req_hold: assert property (
    (fb_stb_o && !fb_ack_i) |=>
      fb_stb_o && $stable(fb_adr_o) && $stable(fb_we_o))
    else $error("frame buffer request changed before ack");
  a_wr_data_hold: assert property (
    (fb_stb_o && fb_we_o && !fb_ack_i) |=> $stable(fb_dat_o))
    else $error("pixel write data changed before ack");
  a_read_before_wr: assert property (
    (fb_stb_o && fb_we_o && !$past(fb_stb_o && fb_we_o)) |->
      $past(fb_stb_o && !fb_we_o && fb_ack_i) && fb_adr_o == $past(fb_adr_o))
    else $error("pixel write not preceded by read of same pixel");
  a_busy_end_clean: assert property (
    $fell(busy_o) |-> !fb_cyc_o && $past(!fb_cyc_o || fb_ack_i))
    else $error("busy dropped with access open");

  c_pix_write: cover property (fb_stb_o && fb_we_o && fb_ack_i);
  c_launch_busy: cover property (
    wb_ack_o && wb_we_i && wb_adr_i[11] && busy_o);
  c_bus_stall: cover property ((wb_cyc_i && wb_stb_i && !wb_ack_o) [*3]);
endmodule // tld_assertions

/* File: sim/tld_fb_model.sv */
/*
  Frame buffer model: byte-wide memory with random ack latency.
  Assumes one pixel per access in the low byte lane.
*/
module tld_fb_model (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [31:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [logic [31:0]];
  logic [1:0] wait_q;

  // unwritten bytes read as a known function of the address
  function automatic logic [7:0] peek(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : a[7:0] ^ 8'h3c;
  endfunction

  initial begin
    ack_o = 1'b0;
    dat_o = 32'h0;
  end

  always @(posedge clk_i) begin
    if (!rstn_i) begin
      ack_o <= 1'b0;
      wait_q <= 2'h0;
    end else if (cyc_i && stb_i && !ack_o && wait_q == 2'h0) begin
      ack_o <= 1'b1;
      dat_o <= {24'h0, peek(adr_i)};
      if (we_i && sel_i[0]) mem[adr_i] = dat_i[7:0];
      wait_q <= 2'($urandom_range(3));
    end else begin
      ack_o <= 1'b0;
      // released bus toggles so stale data never looks valid
      dat_o <= ~dat_o;
      if (cyc_i && stb_i && !ack_o) wait_q <= wait_q - 2'h1;
    end
  end
endmodule // tld_fb_model

/* File: sim/tld_engine_test.sv */
/*
  Self-checking test of the drawing engine: register reads, packed text,
  transparent text, thick patterned and vertical lines. Assumes the
  frame buffer model and the port checker.
*/
module tld_engine_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk_i = 1'b0;
  logic        resetn_i;
  logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [11:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, fb_adr_o, fb_dat_o, fb_dat_i;
  logic        fb_cyc_o, fb_stb_o, fb_we_o, fb_ack_i, busy_o;
  logic [3:0]  fb_sel_o;
  int          n_errors = 0;
  int          compares = 0;
  int          cycles   = 0;
  logic [31:0] rq [$];
  logic [31:0] ea [$];
  logic [11:0] ed [$];
  logic [7:0]  fg, bg;

  always #5 ref_clk_i = ~ref_clk_i;

  tld_engine uut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fb_cyc_o(fb_cyc_o),
    .fb_stb_o(fb_stb_o), .fb_we_o(fb_we_o), .fb_adr_o(fb_adr_o),
    .fb_sel_o(fb_sel_o), .fb_dat_o(fb_dat_o), .fb_dat_i(fb_dat_i),
    .fb_ack_i(fb_ack_i), .busy_o(busy_o));
  tld_fb_model fbm (.clk_i(ref_clk_i), .rstn_i(resetn_i), .cyc_i(fb_cyc_o),
    .stb_i(fb_stb_o), .we_i(fb_we_o), .adr_i(fb_adr_o), .sel_i(fb_sel_o),
    .dat_i(fb_dat_o), .dat_o(fb_dat_i), .ack_o(fb_ack_i));

  function automatic logic [7:0] dflt(input logic [31:0] a);
    return a[7:0] ^ 8'h3c;
  endfunction

  task test_done;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task cmp32(input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t value %h expected %h", $time, g, e);
    end
  endtask

  task cmp_px(input logic [31:0] a, input logic [11:0] d);
    compares++;
    if (ea.size() == 0) begin
      ea.push_back(~a);
      ed.push_back(d);
    end
    if (a !== ea[0] || d !== ed[0]) begin
      n_errors++;
      $display("[ERR] %0t pixel %h=%h expected %h=%h", $time, a, d, ea[0],
               ed[0]);
    end
    void'(ea.pop_front());
    void'(ed.pop_front());
  endtask

  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      $display("[ERR] %0t run did not finish", $time);
      test_done;
    end
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
      cmp32(rq.size() ? rq.pop_front() : ~wb_dat_o, wb_dat_o);
    if (fb_stb_o === 1'b1 && fb_we_o === 1'b1 && fb_ack_i === 1'b1)
      cmp_px(fb_adr_o, {fb_sel_o, fb_dat_o[7:0]});
  end

  task wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge ref_clk_i);
    while (wb_ack_o !== 1'b1) @(posedge ref_clk_i);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task rd(input logic [11:0] a, input logic [31:0] e);
    rq.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask

  task px(input logic [31:0] a, input logic [7:0] v);
    ea.push_back(a);
    ed.push_back({4'h1, v});
  endtask

  task setup(input logic [31:0] c, h, s, b);
    wb(1'b1, tld_pkg::OFS_CTRL, c);
    wb(1'b1, tld_pkg::OFS_WIDTH, 32'h0);
    wb(1'b1, tld_pkg::OFS_HEIGHT, h);
    wb(1'b1, tld_pkg::OFS_SOURCE_COORD_REG, s);
    wb(1'b1, tld_pkg::OFS_BASE, b);
  endtask

  task finish_op(input string name);
    repeat (3) @(posedge ref_clk_i);
    while (busy_o !== 1'b0) @(posedge ref_clk_i);
    cmp32(32'h0, 32'(ea.size()));
    $display("test %s done", name);
  endtask

  // one packed character at base 0x1000, pitch 64, one byte per pixel
  task chr(input logic [31:0] d, input int al, w, h, x, y, input logic tr);
    logic [31:0] a;
    logic        b;
    for (int r = 0; r < h; r++) begin
      for (int c = 0; c < w; c++) begin
        a = 32'h1000 + 32'((y + r) * 64 + x + c);
        b = d[(al + r * w + c) ^ 7];
        if (!tr) px(a, b ? fg : bg);
        else if (b) px(a, fg ^ dflt(a));
      end
    end
    wb(1'b1, 12'h800 | 12'((w - 1) << 2), {16'(y), 16'(x)});
    wb(1'b1, tld_pkg::OFS_DATA, d);
  endtask

  initial begin
    logic [31:0] a;
    logic [7:0]  p;
    logic [31:0] sw [2];
    resetn_i = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i  = 1'b0;
    wb_adr_i = 12'h0;
    wb_dat_i = 32'h0;
    void'($urandom(58));
    repeat (16) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    fg = 8'($urandom);
    bg = 8'($urandom);
    rd(tld_pkg::OFS_CTRL, 32'h0000_00cc);
    rd(tld_pkg::OFS_BPP, 32'h0000_0001);
    wb(1'b1, 12'h030, tld_pkg::ONES32);
    rd(12'h030, 32'h0);
    rd(tld_pkg::OFS_STATUS, 32'h0);
    finish_op("registers");
    wb(1'b1, tld_pkg::OFS_FG, {24'h0, fg});
    wb(1'b1, tld_pkg::OFS_BG, {24'h0, bg});
    wb(1'b1, tld_pkg::OFS_PITCH, 32'h0000_0040);
    // upper alignment bits set on purpose: only five count
    setup(32'h0000_0dcc, 32'h2, 32'h0000_00e3, 32'h1000);
    chr($urandom, 3, 5, 2, 2, 1, 1'b0);
    finish_op("packed opaque");
    // expand must be on as well, or each pixel eats a whole word
    setup(32'h0000_0f66, 32'h3, 32'h0, 32'h1000);
    chr($urandom, 0, 3, 3, 10, 6, 1'b1);
    chr($urandom, 0, 3, 3, 14, 6, 1'b1);
    finish_op("transparent pair");
    setup(32'h0000_30f0, 32'h1, 32'h0, 32'h2000);
    wb(1'b1, tld_pkg::OFS_PATTERN, 32'h4000);
    for (int r = 0; r < 2; r++) begin
      p = dflt(32'h4000 + 32'(r * 4));
      for (int c = 0; c < 6; c++) px(32'h2000 + 32'(r * 64 + c),
                                     p[7 - c] ? fg : bg);
    end
    wb(1'b1, 12'h814, 32'h0);
    finish_op("thick patterned line");
    setup(32'h0000_4066, 32'h0, 32'h0, 32'h3000);
    for (int r = 0; r < 4; r++) begin
      a = 32'h3000 + 32'((2 + r) * 64 + 5);
      px(a, bg ^ dflt(a));
    end
    wb(1'b1, 12'h80c, {16'h2, 16'h5});
    finish_op("vertical line");
    // last strip: background fill first, then transparent strip
    wb(1'b1, tld_pkg::OFS_BPP, 32'h1);
    setup(32'h0000_20cc, 32'h1, 32'h0, 32'h5000);
    for (int i = 0; i < 16; i++) begin
      px(32'h5000 + 32'((i / 8) * 64 + i % 8), bg);
    end
    wb(1'b1, 12'h81c, 32'h0);
    finish_op("strip fill");
    setup(32'h0000_0bcc, 32'h1, 32'h0, 32'h5000);
    for (int i = 0; i < 16; i++) begin
      if (i % 8 == 0) sw[i / 8] = $urandom & 32'h0000_00ff;
      if (sw[i / 8][(i % 8) ^ 7]) begin
        px(32'h5000 + 32'((i / 8) * 64 + i % 8), fg);
      end
    end
    wb(1'b1, 12'h81c, 32'h0);
    rd(tld_pkg::OFS_STATUS, 32'h0000_0001);
    wb(1'b1, tld_pkg::OFS_DATA, sw[0]);
    wb(1'b1, tld_pkg::OFS_DATA, sw[1]);
    finish_op("transparent strip");
    test_done;
  end
endmodule // tld_engine_test

bind tld_engine tld_assertions chk (.ref_clk_i(ref_clk_i),
  .resetn_i(resetn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o),
  .fb_stb_o(fb_stb_o), .fb_cyc_o(fb_cyc_o), .fb_we_o(fb_we_o),
  .fb_adr_o(fb_adr_o), .fb_dat_o(fb_dat_o), .fb_ack_i(fb_ack_i),
  .busy_o(busy_o));
